// >>> design/dcp_cache_policy.sv
// disk cache policy block: caching page store, mode select/sense,
// write completion, read bypass, retention hints and prefetch engine.
// assumes command and medium strobes are synchronous to pclk and that
// the medium answers each prefetch block request with one done pulse.
// How it works
// RULE1: savable flag only reported, ignored on select
// RULE2: select with save flag stores page copy
// RULE3: write-through: good status after medium done
// RULE4: write-back: good status after data received
// RULE5: scale min/max by block count when selected
// RULE6: bypass flag forces reads from medium
// RULE7: retention codes 0, 1h, Fh decoded; rest ignored
// RULE8: read/write hints exported, advisory only
// RULE9: prefetch shortfalls never raise an error
// RULE10: skip prefetch when blocks exceed disable length
// RULE11: zero disable length turns prefetch off
// RULE12: minimum amount fetched despite waiting commands
// RULE13: prefetch starts after previous read's last block
// RULE14: prefetch never passes last medium block
// RULE15: prefetch errors suppressed unless fatal, then deferred
// RULE16: past minimum, abort when command waits
// RULE17: maximum amount fetched when nothing waits
// RULE18: maximum clamped to ceiling
// RULE19: page bytes 2..11 hold bits, codes, four counts
// RULE20: only caching page or all-pages on sense accepted
//
// Design decisions made here: the APB register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module dcp_cache_policy #(
  parameter int LBA_W = 32,
  parameter bit PAGE_SAVABLE = 1'b1
) (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // read command
  input wire logic rd_cmd_valid,
  input wire logic [LBA_W-1:0] rd_cmd_lba,
  input wire logic [15:0] rd_cmd_blocks,
  input wire logic cmd_pending,
  output logic rd_cmd_ready,
  output logic rd_use_cache,
  // write completion
  input wire logic wr_data_received,
  input wire logic wr_medium_done,
  output logic wr_good,
  // retention hints
  output logic [1:0] rd_retain_hint,
  output logic [1:0] wr_retain_hint,
  // medium
  input wire logic [LBA_W-1:0] medium_last_lba,
  output logic pf_req,
  output logic [LBA_W-1:0] pf_lba,
  input wire logic pf_done,
  input wire logic pf_err,
  input wire logic pf_err_fatal,
  output logic pf_err_report,
  // page persistence
  output logic page_save
);

  // ************************************************
  // state
  // ************************************************
  typedef struct packed {
    logic [2:0] pol;
    logic [7:0] ret;
    logic [15:0] dis;
    logic [15:0] mn;
    logic [15:0] mx;
    logic [15:0] ceil;
  } dcp_page_t;

  typedef struct packed {
    dcp_page_t stage;
    dcp_page_t cur;
    dcp_page_t saved;
    dcp_page_t sense;
    logic cmd_err;
    logic pf_err_st;
    logic saved_ok;
    dcp_pkg::dcp_pf_state_t st;
    logic [LBA_W-1:0] lba;
    logic [31:0] cnt;
    logic [31:0] tgt_min;
    logic [31:0] tgt_max;
    logic early_abort;
    logic [31:0] rdata;
    logic ready;
    logic slverr;
    logic rd_ready;
    logic use_cache;
    logic good;
    logic [1:0] rhint;
    logic [1:0] whint;
    logic req;
    logic err_rep;
    logic save;
  } dcp_state_t;

  localparam dcp_page_t PAGE_RST = '{pol: dcp_pkg::RST_POLICY, ret: dcp_pkg::RST_RETENTION,
    dis: dcp_pkg::RST_DIS_LEN, mn: dcp_pkg::RST_MIN_PF, mx: dcp_pkg::RST_MAX_PF,
    ceil: dcp_pkg::RST_CEIL_PF};

  dcp_state_t q;
  dcp_state_t d;

  // see RULE7
  function automatic logic [1:0] ret_decode(input logic [3:0] code);
    logic [1:0] h;
    h = dcp_pkg::HINT_NONE;
    if (code == dcp_pkg::RET_EVICT_FIRST) begin
      h = dcp_pkg::HINT_EVICT;
    end else if (code == dcp_pkg::RET_KEEP) begin
      h = dcp_pkg::HINT_KEEP;
    end
    return h;
  endfunction

  // ************************************************
  // prefetch sizing
  // ************************************************
  logic wbe;
  logic mf;
  logic read_cache_bypass;
  logic [31:0] amt_min;
  logic [31:0] amt_max;
  logic [31:0] avail;
  logic [LBA_W-1:0] start_lba;
  logic pf_allowed;

  assign wbe = q.cur.pol[2];
  assign mf = q.cur.pol[1];
  assign read_cache_bypass = q.cur.pol[0];
  assign start_lba = rd_cmd_lba + LBA_W'(rd_cmd_blocks); // see RULE13

  always_comb begin
    amt_min = mf ? 32'(q.cur.mn) * 32'(rd_cmd_blocks) : 32'(q.cur.mn); // see RULE5
    amt_max = mf ? 32'(q.cur.mx) * 32'(rd_cmd_blocks) : 32'(q.cur.mx); // see RULE5
    if (amt_max > 32'(q.cur.ceil)) begin
      amt_max = 32'(q.cur.ceil); // see RULE18
    end
    if (start_lba > medium_last_lba || start_lba < rd_cmd_lba) begin
      avail = 32'h0;
    end else begin
      avail = 32'(medium_last_lba - start_lba) + 32'h1;
    end
    if (amt_max > avail) begin
      amt_max = avail; // see RULE14
    end
    if (amt_min > amt_max) begin
      amt_min = amt_max;
    end
    // see RULE10 see RULE11
    pf_allowed = (q.cur.dis != 16'h0000) && (rd_cmd_blocks <= q.cur.dis) &&
      (amt_max != 32'h0);
  end

  // ************************************************
  // next state
  // ************************************************
  logic acc;
  logic wr;
  logic [5:0] code;
  logic last_blk;
  logic abort_now;

  assign acc = psel && penable && !q.ready;
  assign wr = acc && pwrite;
  assign code = pwdata[dcp_pkg::CMD_CODE_LSB +: 6];
  assign last_blk = (q.cnt + 32'h1) >= q.tgt_max;
  // see RULE16 see RULE12
  assign abort_now = q.early_abort && cmd_pending && ((q.cnt + 32'h1) > q.tgt_min);

  always_comb begin
    d = q;
    d.ready = acc;
    d.slverr = 1'b0;
    d.save = 1'b0;
    d.err_rep = 1'b0;
    // page staging; savable bit in written data is dropped, see RULE1 see RULE19
    if (wr && paddr == dcp_pkg::ADDR_PAGE_W0) begin
      d.stage.pol = pwdata[18:16];
      d.stage.ret = pwdata[31:24];
    end
    if (wr && paddr == dcp_pkg::ADDR_PAGE_W1) begin
      d.stage.dis = {pwdata[7:0], pwdata[15:8]};
      d.stage.mn = {pwdata[23:16], pwdata[31:24]};
    end
    if (wr && paddr == dcp_pkg::ADDR_PAGE_W2) begin
      d.stage.mx = {pwdata[7:0], pwdata[15:8]};
      d.stage.ceil = {pwdata[23:16], pwdata[31:24]};
    end
    if (wr && paddr == dcp_pkg::ADDR_STATUS) begin
      d.cmd_err = q.cmd_err && !pwdata[dcp_pkg::ST_CMD_ERR_BIT];
      d.pf_err_st = q.pf_err_st && !pwdata[dcp_pkg::ST_PF_ERR_BIT];
    end
    if (wr && paddr == dcp_pkg::ADDR_MODE_CMD) begin
      if (pwdata[dcp_pkg::CMD_OP_SELECT_BIT]) begin
        if (code == dcp_pkg::PAGE_CACHING) begin
          d.cur = q.stage;
          if (pwdata[dcp_pkg::CMD_SAVE_BIT] && PAGE_SAVABLE) begin
            d.saved = q.stage; // see RULE2
            d.save = 1'b1;
            d.saved_ok = 1'b1;
          end
        end else begin
          d.cmd_err = 1'b1; // see RULE20
        end
      end else if (code == dcp_pkg::PAGE_CACHING || code == dcp_pkg::PAGE_ALL) begin
        d.sense = q.cur;
      end else begin
        d.cmd_err = 1'b1; // see RULE20
      end
    end
    if (acc) begin
      unique case (paddr)
        dcp_pkg::ADDR_PAGE_W0: d.rdata = {q.sense.ret, 5'h00, q.sense.pol,
          dcp_pkg::PAGE_LENGTH, PAGE_SAVABLE, 1'b0, dcp_pkg::PAGE_CACHING}; // see RULE1
        dcp_pkg::ADDR_PAGE_W1: d.rdata = {q.sense.mn[7:0], q.sense.mn[15:8],
          q.sense.dis[7:0], q.sense.dis[15:8]};
        dcp_pkg::ADDR_PAGE_W2: d.rdata = {q.sense.ceil[7:0], q.sense.ceil[15:8],
          q.sense.mx[7:0], q.sense.mx[15:8]};
        dcp_pkg::ADDR_MODE_CMD: d.rdata = 32'h0;
        dcp_pkg::ADDR_STATUS: d.rdata = {28'h0, q.saved_ok, q.st == dcp_pkg::PF_FETCH,
          q.pf_err_st, q.cmd_err};
        dcp_pkg::ADDR_PF_COUNT: d.rdata = q.cnt;
        default: begin
          d.rdata = 32'h0;
          d.slverr = 1'b1;
        end
      endcase
    end
    // write completion, see RULE3 see RULE4
    d.good = wbe ? wr_data_received : wr_medium_done;
    d.use_cache = !read_cache_bypass; // see RULE6
    d.rhint = ret_decode(q.cur.ret[7:4]); // see RULE8
    d.whint = ret_decode(q.cur.ret[3:0]); // see RULE8
    // prefetch engine
    unique case (q.st)
      dcp_pkg::PF_IDLE: begin
        if (rd_cmd_valid && pf_allowed) begin
          d.st = dcp_pkg::PF_FETCH;
          d.lba = start_lba; // see RULE13
          d.cnt = 32'h0;
          d.tgt_min = amt_min;
          d.tgt_max = amt_max; // see RULE17
          d.early_abort = q.cur.mn != q.cur.mx; // see RULE16
        end
      end
      dcp_pkg::PF_FETCH: begin
        if (pf_done) begin
          d.cnt = q.cnt + 32'h1;
          d.lba = q.lba + LBA_W'(1);
          // shortfalls end quietly, see RULE9; only fatal errors surface, see RULE15
          if (pf_err && pf_err_fatal) begin
            d.pf_err_st = 1'b1;
            d.err_rep = 1'b1;
          end
          if (last_blk || abort_now || pf_err) begin
            d.st = dcp_pkg::PF_IDLE; // see RULE14
          end
        end
      end
    endcase
    d.req = d.st == dcp_pkg::PF_FETCH;
    d.rd_ready = d.st == dcp_pkg::PF_IDLE;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.stage <= PAGE_RST;
      q.cur <= PAGE_RST;
      q.saved <= PAGE_RST;
      q.sense <= PAGE_RST;
      q.st <= dcp_pkg::PF_IDLE;
      q.rd_ready <= 1'b1;
      q.use_cache <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // ************************************************
  // outputs
  // ************************************************
  assign prdata = q.rdata;
  assign pready = q.ready;
  assign pslverr = q.slverr;
  assign rd_cmd_ready = q.rd_ready;
  assign rd_use_cache = q.use_cache;
  assign wr_good = q.good;
  assign rd_retain_hint = q.rhint;
  assign wr_retain_hint = q.whint;
  assign pf_req = q.req;
  assign pf_lba = q.lba;
  assign pf_err_report = q.err_rep;
  assign page_save = q.save;

  // ************************************************
  // assertions
  // ************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  wr_through_a: assert property ( // see RULE3
    !wbe && !$past(wbe) && wr_good |-> $past(wr_medium_done))
    else $error("write good without medium done");
  wt_early_a: assert property ( // see RULE3
    !wbe && !wr_medium_done |=> !wr_good)
    else $error("write-through good before medium done");
  wr_back_a: assert property ( // see RULE4
    wbe && wr_data_received ##1 $past(wbe) |-> wr_good)
    else $error("write-back good missing");
  rd_bypass_a: assert property ( // see RULE6
    $past(read_cache_bypass) |-> !rd_use_cache)
    else $error("cache used while bypassed");
  ret_keep_a: assert property ( // see RULE7
    q.cur.ret[7:4] == 4'hF ##1 $stable(q.cur.ret) |-> rd_retain_hint == 2'h2)
    else $error("keep hint not decoded");
  pf_quiet_a: assert property ( // see RULE9
    pf_done && !pf_err |=> !pf_err_report)
    else $error("prefetch shortfall reported");
  pf_off_a: assert property ( // see RULE11
    q.st == dcp_pkg::PF_IDLE && rd_cmd_valid && q.cur.dis == 16'h0 |=> !pf_req)
    else $error("prefetch with zero disable length");
  pf_long_a: assert property ( // see RULE10
    q.st == dcp_pkg::PF_IDLE && rd_cmd_valid && rd_cmd_blocks > q.cur.dis |=> !pf_req)
    else $error("prefetch on long transfer");
  pf_start_a: assert property ( // see RULE13
    q.st == dcp_pkg::PF_IDLE && rd_cmd_valid && pf_allowed |=>
    pf_req && pf_lba == $past(start_lba))
    else $error("prefetch start address wrong");
  pf_end_a: assert property ( // see RULE14
    pf_req |-> pf_lba <= medium_last_lba)
    else $error("prefetch past medium end");
  pf_min_a: assert property ( // see RULE12
    pf_req && pf_done && !pf_err && (q.cnt + 32'h1) < q.tgt_min |=> pf_req)
    else $error("prefetch stopped before minimum");
  pf_abort_a: assert property ( // see RULE16
    pf_req && pf_done && cmd_pending && q.early_abort && q.cnt >= q.tgt_min |=> !pf_req)
    else $error("prefetch not aborted for waiting command");
  pf_full_a: assert property ( // see RULE17
    pf_req && pf_done && (q.cnt + 32'h1) >= q.tgt_max |=> !pf_req && rd_cmd_ready)
    else $error("prefetch ran past maximum");
  pf_ceil_a: assert property ( // see RULE18
    pf_req |-> q.tgt_max <= 32'(q.cur.ceil) || $changed(q.cur))
    else $error("prefetch amount above ceiling");
  pf_err_a: assert property ( // see RULE15
    pf_req && pf_done && pf_err && !pf_err_fatal |=> !pf_err_report)
    else $error("suppressed prefetch error reported");
  save_a: assert property ( // see RULE2
    page_save |-> q.saved == q.cur && PAGE_SAVABLE)
    else $error("page save without copy");
  sel_code_a: assert property ( // see RULE20
    psel && penable && pwrite && !pready && paddr == dcp_pkg::ADDR_MODE_CMD &&
    pwdata[dcp_pkg::CMD_OP_SELECT_BIT] && code != dcp_pkg::PAGE_CACHING |=> q.cmd_err)
    else $error("bad select code accepted");

  pf_run_c: cover property (pf_req ##1 pf_done ##1 !pf_req);
  pf_abort_c: cover property (pf_req && pf_done && abort_now);
  save_c: cover property (page_save);
  wr_back_c: cover property (wbe && wr_good);

endmodule
`default_nettype wire

// >>> design/dcp_pkg.sv
// package of the disk cache policy block: register map, page layout,
// command codes and reset values.
// assumes an apb master with 32-bit data and one aligned word per register.
package dcp_pkg;

  // ************************************************
  // register map (byte addresses)
  // ************************************************
  localparam logic [7:0] ADDR_PAGE_W0 = 8'h00;
  localparam logic [7:0] ADDR_PAGE_W1 = 8'h04;
  localparam logic [7:0] ADDR_PAGE_W2 = 8'h08;
  localparam logic [7:0] ADDR_MODE_CMD = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_PF_COUNT = 8'h14;

  // ************************************************
  // mode command register fields
  // ************************************************
  localparam int CMD_CODE_LSB = 0;
  localparam int CMD_OP_SELECT_BIT = 8;
  localparam int CMD_SAVE_BIT = 9;

  // ************************************************
  // status register fields
  // ************************************************
  localparam int ST_CMD_ERR_BIT = 0;
  localparam int ST_PF_ERR_BIT = 1;
  localparam int ST_PF_BUSY_BIT = 2;
  localparam int ST_SAVED_BIT = 3;

  // ************************************************
  // page codes and page header
  // ************************************************
  localparam logic [5:0] PAGE_CACHING = 6'h08;
  localparam logic [5:0] PAGE_ALL = 6'h3F;
  localparam logic [7:0] PAGE_LENGTH = 8'h0A;

  // ************************************************
  // retention codes and decoded hints
  // ************************************************
  localparam logic [3:0] RET_EQUAL = 4'h0;
  localparam logic [3:0] RET_EVICT_FIRST = 4'h1;
  localparam logic [3:0] RET_KEEP = 4'hF;
  localparam logic [1:0] HINT_NONE = 2'h0;
  localparam logic [1:0] HINT_EVICT = 2'h1;
  localparam logic [1:0] HINT_KEEP = 2'h2;

  // ************************************************
  // page reset values
  // ************************************************
  localparam logic [2:0] RST_POLICY = 3'h0;
  localparam logic [7:0] RST_RETENTION = 8'h00;
  localparam logic [15:0] RST_DIS_LEN = 16'hFFFF;
  localparam logic [15:0] RST_MIN_PF = 16'h0000;
  localparam logic [15:0] RST_MAX_PF = 16'h0010;
  localparam logic [15:0] RST_CEIL_PF = 16'hFFFF;

  // ************************************************
  // prefetch engine states
  // ************************************************
  typedef enum logic [1:0] {
    PF_IDLE = 2'b01,
    PF_FETCH = 2'b10
  } dcp_pf_state_t;

endpackage

// >>> bench/dcp_medium_model.sv
// medium model for the disk cache policy bench: answers each prefetch
// block request with one done pulse after a set latency.
// assumes pf_req and pf_lba are registered on pclk by the design.
`timescale 1ns/10ps
`default_nettype none
module dcp_medium_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // prefetch request
  input wire logic pf_req,
  input wire logic [31:0] pf_lba,
  output logic pf_done,
  output logic pf_err,
  output logic pf_err_fatal,
  // scenario control
  input wire logic [3:0] lat,
  input wire logic [15:0] err_at,
  input wire logic err_fatal,
  // observation
  output logic [15:0] run_cnt,
  output logic [31:0] run_first,
  output logic [15:0] seq_bad
);
  logic in_run;
  initial begin
    pf_done = 1'b0;
    pf_err = 1'b0;
    pf_err_fatal = 1'b0;
    run_cnt = 16'h0000;
    run_first = 32'h00000000;
    seq_bad = 16'h0000;
    in_run = 1'b0;
    forever begin
      @(posedge pclk);
      if (presetn !== 1'b1 || pf_req !== 1'b1) begin
        in_run = 1'b0;
      end else begin
        if (!in_run) begin
          in_run = 1'b1;
          run_first = pf_lba;
          run_cnt = 16'h0000;
        end
        repeat (lat) @(posedge pclk);
        // blocks must come in strict ascending order
        if (pf_lba !== run_first + run_cnt) seq_bad = seq_bad + 16'h0001;
        run_cnt = run_cnt + 16'h0001;
        pf_done <= 1'b1;
        pf_err <= (run_cnt == err_at);
        pf_err_fatal <= (run_cnt == err_at) && err_fatal;
        @(posedge pclk);
        pf_done <= 1'b0;
        pf_err <= 1'b0;
        pf_err_fatal <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// >>> bench/dcp_cache_policy_tb_top.sv
// self-checking bench of the disk cache policy block: registers over apb,
// write completion, read policy, hints and prefetch runs.
// assumes dcp_pkg and the medium model are compiled first.
`timescale 1ns/10ps
`default_nettype none
module dcp_cache_policy_tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd_cmd_lba, medium_last_lba, pf_lba, run_first;
  logic rd_cmd_valid, cmd_pending, rd_cmd_ready, rd_use_cache, err_fatal;
  logic [15:0] rd_cmd_blocks, err_at, run_cnt, seq_bad;
  logic wr_data_received, wr_medium_done, wr_good, pf_req, pf_done, pf_err, pf_err_fatal;
  logic pf_err_report, page_save;
  logic [1:0] rd_retain_hint, wr_retain_hint;
  logic [3:0] lat;
  int error_cnt, tests_run, save_cnt, report_cnt;

  dcp_cache_policy #(.LBA_W(32), .PAGE_SAVABLE(1'b1)) i_dut (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .rd_cmd_valid, .rd_cmd_lba,
    .rd_cmd_blocks, .cmd_pending, .rd_cmd_ready, .rd_use_cache, .wr_data_received,
    .wr_medium_done, .wr_good, .rd_retain_hint, .wr_retain_hint, .medium_last_lba, .pf_req,
    .pf_lba, .pf_done, .pf_err, .pf_err_fatal, .pf_err_report, .page_save);
  dcp_medium_model i_med (.pclk, .presetn, .pf_req, .pf_lba, .pf_done, .pf_err,
    .pf_err_fatal, .lat, .err_at, .err_fatal, .run_cnt, .run_first, .seq_bad);

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (page_save === 1'b1) save_cnt++;
    if (pf_err_report === 1'b1) report_cnt++;
  end

  // ************************************************
  // shared tasks
  // ************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    chk(32'(n), 32'h00000002);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h00000000, q, e);
    chk(q & m, x);
  endtask
  task automatic set_page(input logic [2:0] pol, input logic [7:0] ret, input logic [15:0] dis,
                          input logic [15:0] mn, input logic [15:0] mx, input logic [15:0] cl,
                          input logic save);
    wr(dcp_pkg::ADDR_PAGE_W0, {ret, 5'h00, pol, 16'h0000});
    wr(dcp_pkg::ADDR_PAGE_W1, {mn[7:0], mn[15:8], dis[7:0], dis[15:8]});
    wr(dcp_pkg::ADDR_PAGE_W2, {cl[7:0], cl[15:8], mx[7:0], mx[15:8]});
    wr(dcp_pkg::ADDR_MODE_CMD, {22'h000000, save, 1'b1, 2'h0, dcp_pkg::PAGE_CACHING});
    repeat (3) @(posedge pclk);
  endtask
  task automatic pf_run(input logic [15:0] blk, input logic pend, input logic [15:0] expc);
    int n;
    n = 0;
    cmd_pending <= pend;
    rd_cmd_lba <= 32'h00000100;
    rd_cmd_blocks <= blk;
    rd_cmd_valid <= 1'b1;
    @(posedge pclk);
    rd_cmd_valid <= 1'b0;
    @(posedge pclk);
    chk({31'h0, pf_req}, {31'h0, expc != 16'h0000});
    while (rd_cmd_ready !== 1'b1 && n < 500) begin
      @(posedge pclk);
      n++;
    end
    chk({31'h0, rd_cmd_ready}, 32'h00000001);
    if (expc != 16'h0000) begin
      chk({16'h0, run_cnt}, {16'h0, expc});
      chk(run_first, 32'h00000100 + blk);
      chk({16'h0, seq_bad}, 32'h00000000);
    end
    cmd_pending <= 1'b0;
    @(posedge pclk);
  endtask
  function automatic logic [1:0] hint_of(input logic [3:0] c);
    return (c == 4'h1) ? 2'h1 : (c == 4'hF) ? 2'h2 : 2'h0;
  endfunction

  // ************************************************
  // scenarios
  // ************************************************
  task automatic t_regs();
    logic [31:0] q;
    logic e;
    rd(dcp_pkg::ADDR_PAGE_W0, 32'hFFFFFFFF, 32'h00000A88);
    rd(dcp_pkg::ADDR_PAGE_W1, 32'hFFFFFFFF, 32'h0000FFFF);
    rd(dcp_pkg::ADDR_PAGE_W2, 32'hFFFFFFFF, 32'hFFFF1000);
    apb(1'b0, 8'h20, 32'h00000000, q, e);
    chk({q[30:0], e}, 32'h00000001);
    $display("test regs done");
  endtask
  task automatic t_prefetch();
    pf_run(16'h0004, 1'b0, 16'h0010);
    rd(dcp_pkg::ADDR_PF_COUNT, 32'hFFFFFFFF, 32'h00000010);
    set_page(3'h0, 8'h00, 16'hFFFF, 16'h0002, 16'h0008, 16'hFFFF, 1'b0);
    pf_run(16'h0004, 1'b1, 16'h0003);
    pf_run(16'h0004, 1'b0, 16'h0008);
    set_page(3'h0, 8'h00, 16'hFFFF, 16'h0004, 16'h0004, 16'hFFFF, 1'b0);
    pf_run(16'h0004, 1'b1, 16'h0004);
    set_page(3'h2, 8'h00, 16'hFFFF, 16'h0001, 16'h0002, 16'hFFFF, 1'b0);
    pf_run(16'h0003, 1'b0, 16'h0006);
    set_page(3'h0, 8'h00, 16'hFFFF, 16'h0000, 16'h0008, 16'h0005, 1'b0);
    pf_run(16'h0004, 1'b0, 16'h0005);
    set_page(3'h0, 8'h00, 16'h0004, 16'h0000, 16'h0008, 16'hFFFF, 1'b0);
    pf_run(16'h0005, 1'b0, 16'h0000);
    pf_run(16'h0004, 1'b0, 16'h0008);
    set_page(3'h0, 8'h00, 16'h0000, 16'h0000, 16'h0008, 16'hFFFF, 1'b0);
    pf_run(16'h0000, 1'b0, 16'h0000);
    set_page(3'h0, 8'h00, 16'hFFFF, 16'h0000, 16'h0008, 16'hFFFF, 1'b0);
    medium_last_lba <= 32'h00000106;
    pf_run(16'h0004, 1'b0, 16'h0003);
    medium_last_lba <= 32'h0000FFFF;
    $display("test prefetch done");
  endtask
  task automatic t_errors();
    int r;
    lat <= 4'h1;
    err_at <= 16'h0002;
    err_fatal <= 1'b0;
    r = report_cnt;
    pf_run(16'h0004, 1'b0, 16'h0002);
    chk(report_cnt - r, 32'h00000000);
    rd(dcp_pkg::ADDR_STATUS, 32'h00000003, 32'h00000000);
    err_fatal <= 1'b1;
    pf_run(16'h0004, 1'b0, 16'h0002);
    chk(report_cnt - r, 32'h00000001);
    rd(dcp_pkg::ADDR_STATUS, 32'h00000002, 32'h00000002);
    wr(dcp_pkg::ADDR_STATUS, 32'h00000002);
    rd(dcp_pkg::ADDR_STATUS, 32'h00000002, 32'h00000000);
    err_at <= 16'h0000;
    lat <= 4'h0;
    $display("test errors done");
  endtask
  task automatic t_mode();
    int s;
    wr(dcp_pkg::ADDR_MODE_CMD, 32'h0000013F);
    rd(dcp_pkg::ADDR_STATUS, 32'h00000001, 32'h00000001);
    wr(dcp_pkg::ADDR_STATUS, 32'h00000001);
    wr(dcp_pkg::ADDR_MODE_CMD, 32'h0000003F);
    rd(dcp_pkg::ADDR_STATUS, 32'h00000001, 32'h00000000);
    wr(dcp_pkg::ADDR_MODE_CMD, 32'h00000005);
    rd(dcp_pkg::ADDR_STATUS, 32'h00000001, 32'h00000001);
    wr(dcp_pkg::ADDR_STATUS, 32'h00000001);
    s = save_cnt;
    set_page(3'h6, 8'h1F, 16'hFFFF, 16'h0000, 16'h0010, 16'hFFFF, 1'b0);
    chk(save_cnt - s, 32'h00000000);
    wr(dcp_pkg::ADDR_MODE_CMD, 32'h00000008);
    rd(dcp_pkg::ADDR_PAGE_W0, 32'hFF07FFFF, 32'h1F060A88);
    set_page(3'h0, 8'h00, 16'hFFFF, 16'h0000, 16'h0010, 16'hFFFF, 1'b1);
    chk(save_cnt - s, 32'h00000001);
    rd(dcp_pkg::ADDR_STATUS, 32'h00000008, 32'h00000008);
    $display("test mode done");
  endtask
  task automatic t_policy();
    logic [3:0] c[4];
    c = '{4'h0, 4'h1, 4'hF, 4'h5};
    set_page(3'h1, 8'h00, 16'hFFFF, 16'h0000, 16'h0010, 16'hFFFF, 1'b0);
    chk({31'h0, rd_use_cache}, 32'h00000000);
    for (int i = 0; i < 4; i++) begin
      set_page(3'h0, {c[i], c[3-i]}, 16'hFFFF, 16'h0000, 16'h0010, 16'hFFFF, 1'b0);
      chk({30'h0, rd_retain_hint}, {30'h0, hint_of(c[i])});
      chk({30'h0, wr_retain_hint}, {30'h0, hint_of(c[3-i])});
    end
    chk({31'h0, rd_use_cache}, 32'h00000001);
    $display("test policy done");
  endtask
  task automatic wr_case(input logic wbe);
    wr_data_received <= 1'b1;
    @(posedge pclk);
    wr_data_received <= 1'b0;
    @(posedge pclk);
    chk({31'h0, wr_good}, {31'h0, wbe});
    repeat (3) @(posedge pclk);
    wr_medium_done <= 1'b1;
    @(posedge pclk);
    wr_medium_done <= 1'b0;
    @(posedge pclk);
    chk({31'h0, wr_good}, {31'h0, !wbe});
  endtask
  task automatic t_write();
    set_page(3'h4, 8'h00, 16'hFFFF, 16'h0000, 16'h0010, 16'hFFFF, 1'b0);
    wr_case(1'b1);
    set_page(3'h0, 8'h00, 16'hFFFF, 16'h0000, 16'h0010, 16'hFFFF, 1'b0);
    wr_case(1'b0);
    $display("test write done");
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    complete_run();
  end
  initial begin
    {presetn, psel, penable, pwrite, rd_cmd_valid, cmd_pending, err_fatal} = 7'h00;
    {wr_data_received, wr_medium_done, paddr, pwdata, rd_cmd_lba, rd_cmd_blocks} = 90'h0;
    {err_at, lat} = 20'h00000;
    medium_last_lba = 32'h0000FFFF;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_prefetch();
    t_errors();
    t_mode();
    t_policy();
    t_write();
    complete_run();
  end
endmodule
`default_nettype wire
